// file: rtl/ocm_channel.sv
// One sense input: debounce of comparator samples and match flag
`timescale 1ns/1ps
`default_nettype none
module ocm_channel
  import ocm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic enabled,
  input wire logic sample_valid,
  input wire logic sample_value,
  input wire logic [1:0] sample_step,
  input wire logic [7:0] period,
  // Results
  output logic match_reg,
  output logic changed,
  output logic first_valid
);
  logic last_reg;
  logic seen_reg;
  logic [OCM_CNT_W-1:0] cnt_reg;
  logic [OCM_CNT_W-1:0] cnt_next;
  logic commit;

  always_comb begin
    if (sample_value != last_reg) begin
      cnt_next = '0;
    end else if (cnt_reg >= {1'b0, period}) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + {{(OCM_CNT_W-2){1'b0}}, sample_step};
    end
  end

  // Commit only after the value held through the whole period
  assign commit = enabled && sample_valid && (sample_value == last_reg)
                  && (cnt_next >= {1'b0, period});
  assign changed = commit && (match_reg != sample_value)
                   || (!enabled && match_reg);
  assign first_valid = commit && !seen_reg;

  always_ff @(posedge clk) begin
    if (reset || !enabled) begin
      last_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (sample_valid) begin
      last_reg <= sample_value;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !enabled) begin
      match_reg <= 1'b0;
    end else if (commit) begin
      match_reg <= sample_value;
    end
  end

  // First result after the debouncer is first enabled, never re-armed
  always_ff @(posedge clk) begin
    if (reset) begin
      seen_reg <= 1'b0;
    end else if (commit) begin
      seen_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ocm_monitor.sv
// Overcurrent sense monitor: registers, sample scheduler and comparator control
`timescale 1ns/1ps
`default_nettype none
module ocm_monitor
  import ocm_pkg::*;
#(
  parameter int SAMPLE_CYCLES = OCM_SAMPLE_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // Analog comparator
  output logic comp_power_en,
  output logic comp_sel_two,
  output logic [9:0] dac_threshold,
  input wire logic cmp_result,
  // Interrupt
  output logic overcurrent_alert_irq
);
  logic [1:0] ctl_mode_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] debounce_reg;
  logic [9:0] thr_one_reg;
  logic [9:0] thr_two_reg;
  logic [7:0] thr_stage_reg;
  logic [1:0] chg_reg;
  logic [1:0] vld_reg;
  logic [15:0] tick_cnt_reg;
  logic tick;
  logic sel_two_reg;
  logic settled_reg;
  logic [2:0] cmp_sync_reg;
  logic cmp_filt_reg;
  logic running;
  logic [1:0] step;
  logic [1:0] en_ch;
  logic [1:0] match;
  logic [1:0] changed;
  logic [1:0] first;
  logic [1:0] sample_valid;
  logic wr_ctl;
  logic wr_chg;

  assign running = (ctl_mode_reg != OCM_MODE_OFF);
  assign en_ch = ctl_mode_reg;
  assign wr_ctl = reg_wr_en && (reg_addr == OCM_ADDR_CTL);
  assign wr_chg = reg_wr_en && (reg_addr == OCM_ADDR_CHG);

  // Control register writes; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_mode_reg <= OCM_MODE_OFF;
      irq_en_reg <= OCM_REG_RESET;
      debounce_reg <= OCM_DEBOUNCE_RESET;
    end else if (reg_wr_en) begin
      if (wr_ctl) begin
        ctl_mode_reg <= reg_wr_data[1:0];
      end
      if (reg_addr == OCM_ADDR_IRQ_EN) begin
        irq_en_reg <= {reg_wr_data[7:6], 4'h0, reg_wr_data[1:0]};
      end
      // Software keeps this steady while the debouncer runs
      if (reg_addr == OCM_ADDR_DEBOUNCE) begin
        debounce_reg <= reg_wr_data;
      end
    end
  end

  // Threshold: low byte staged, full value applied on the high byte
  always_ff @(posedge clk) begin
    if (reset) begin
      thr_stage_reg <= OCM_REG_RESET;
      thr_one_reg <= '0;
      thr_two_reg <= '0;
    end else if (reg_wr_en) begin
      if (reg_addr == OCM_ADDR_THR1_LO || reg_addr == OCM_ADDR_THR2_LO) begin
        thr_stage_reg <= reg_wr_data;
      end
      if (reg_addr == OCM_ADDR_THR1_HI) begin
        thr_one_reg <= {reg_wr_data[1:0], thr_stage_reg};
      end
      if (reg_addr == OCM_ADDR_THR2_HI) begin
        thr_two_reg <= {reg_wr_data[1:0], thr_stage_reg};
      end
    end
  end

  // 100 us sample tick; restarts whenever the mode is written
  assign tick = (tick_cnt_reg == 16'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (reset || wr_ctl || !running) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Channel select: a sample is taken one tick after selection so the
  // comparator and DAC have a full period to settle
  always_ff @(posedge clk) begin
    if (reset || wr_ctl) begin
      sel_two_reg <= wr_ctl && (reg_wr_data[1:0] == OCM_MODE_TWO);
      settled_reg <= 1'b0;
    end else if (tick) begin
      settled_reg <= 1'b1;
      if (ctl_mode_reg == OCM_MODE_BOTH) begin
        sel_two_reg <= !sel_two_reg;
      end else begin
        sel_two_reg <= (ctl_mode_reg == OCM_MODE_TWO);
      end
    end
  end

  // Comparator output is asynchronous to clk
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_sync_reg <= 3'h0;
      cmp_filt_reg <= 1'b0;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[1:0], cmp_result};
      if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
        cmp_filt_reg <= cmp_sync_reg[2];
      end
    end
  end

  assign sample_valid[0] = tick && settled_reg && !sel_two_reg && en_ch[0];
  assign sample_valid[1] = tick && settled_reg && sel_two_reg && en_ch[1];
  assign step = (ctl_mode_reg == OCM_MODE_BOTH) ? 2'h2 : 2'h1;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    ocm_channel u_ch (
      .clk(clk),
      .reset(reset),
      .enabled(en_ch[i]),
      .sample_valid(sample_valid[i]),
      .sample_value(cmp_filt_reg),
      .sample_step(step),
      .period(debounce_reg),
      .match_reg(match[i]),
      .changed(changed[i]),
      .first_valid(first[i])
    );
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      chg_reg <= 2'h0;
      vld_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (changed[i]) begin
          chg_reg[i] <= 1'b1;
        end else if (wr_chg && reg_wr_data[i]) begin
          chg_reg[i] <= 1'b0;
        end
        if (first[i]) begin
          vld_reg[i] <= 1'b1;
        end else if (wr_chg && reg_wr_data[OCM_VLD_LSB + i]) begin
          vld_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overcurrent_alert_irq <= 1'b0;
    end else begin
      overcurrent_alert_irq <= |({vld_reg, chg_reg} & {irq_en_reg[7:6], irq_en_reg[1:0]});
    end
  end

  // Read data; unmapped addresses and reserved bits read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rd_data <= OCM_REG_RESET;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        OCM_ADDR_CTL: reg_rd_data <= {running, 5'h00, ctl_mode_reg};
        OCM_ADDR_MATCH: reg_rd_data <= {6'h00, match};
        OCM_ADDR_CHG: reg_rd_data <= {vld_reg, 4'h0, chg_reg};
        OCM_ADDR_IRQ_EN: reg_rd_data <= irq_en_reg;
        OCM_ADDR_THR1_LO: reg_rd_data <= thr_one_reg[7:0];
        OCM_ADDR_THR1_HI: reg_rd_data <= {6'h00, thr_one_reg[9:8]};
        OCM_ADDR_THR2_LO: reg_rd_data <= thr_two_reg[7:0];
        OCM_ADDR_THR2_HI: reg_rd_data <= {6'h00, thr_two_reg[9:8]};
        OCM_ADDR_DEBOUNCE: reg_rd_data <= debounce_reg;
        default: reg_rd_data <= OCM_REG_RESET;
      endcase
    end
  end

  // Comparator and DAC drive
  always_ff @(posedge clk) begin
    if (reset) begin
      comp_power_en <= 1'b0;
      comp_sel_two <= 1'b0;
      dac_threshold <= '0;
    end else begin
      comp_power_en <= running;
      comp_sel_two <= sel_two_reg;
      dac_threshold <= sel_two_reg ? thr_two_reg : thr_one_reg;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ocm_pkg.sv
// Constants for the overcurrent sense monitor
package ocm_pkg;
  localparam logic [7:0] OCM_ADDR_CTL = 8'h80;
  localparam logic [7:0] OCM_ADDR_MATCH = 8'h81;
  localparam logic [7:0] OCM_ADDR_CHG = 8'h82;
  localparam logic [7:0] OCM_ADDR_IRQ_EN = 8'h83;
  localparam logic [7:0] OCM_ADDR_THR1_LO = 8'h84;
  localparam logic [7:0] OCM_ADDR_THR1_HI = 8'h85;
  localparam logic [7:0] OCM_ADDR_THR2_LO = 8'h86;
  localparam logic [7:0] OCM_ADDR_THR2_HI = 8'h87;
  localparam logic [7:0] OCM_ADDR_DEBOUNCE = 8'h88;
  localparam int OCM_CTL_RUNNING_BIT = 7;
  localparam int OCM_VLD_LSB = 6;
  localparam logic [1:0] OCM_MODE_OFF = 2'h0;
  localparam logic [1:0] OCM_MODE_ONE = 2'h1;
  localparam logic [1:0] OCM_MODE_TWO = 2'h2;
  localparam logic [1:0] OCM_MODE_BOTH = 2'h3;
  localparam logic [7:0] OCM_DEBOUNCE_RESET = 8'h0F;
  localparam logic [7:0] OCM_REG_RESET = 8'h00;
  localparam int OCM_CLK_MHZ = 100;
  localparam int OCM_SAMPLE_US = 100;
  localparam int OCM_SAMPLE_CYCLES = OCM_SAMPLE_US * OCM_CLK_MHZ;
  localparam int OCM_CNT_W = 9;
endpackage

// file: tb/ocm_comparator_model.sv
// Behavioural comparator and threshold DAC facing the monitor
`timescale 1ns/1ps
`default_nettype none
module ocm_comparator_model (
  // Clock
  input wire logic clk,
  // Controls from the monitor
  input wire logic comp_power_en,
  input wire logic comp_sel_two,
  input wire logic [9:0] dac_threshold,
  // Sensed currents from the bench
  input wire logic [9:0] sense_one_level,
  input wire logic [9:0] sense_two_level,
  // Result
  output logic cmp_result
);
  logic idle_toggle = 1'b0;
  // Powered down the output is meaningless, so it wanders rather than rest
  always @(posedge clk) idle_toggle <= ~idle_toggle;
  assign cmp_result = !comp_power_en ? idle_toggle :
    (comp_sel_two ? sense_two_level : sense_one_level) > dac_threshold;
endmodule
`default_nettype wire

// file: tb/ocm_monitor_bench.sv
// Bench for the overcurrent sense monitor
`timescale 1ns/1ps
`default_nettype none
module ocm_monitor_bench;
  logic clk, reset, reg_wr_en, reg_rd_en, comp_power_en, comp_sel_two, cmp_result, irq;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [9:0] dac_threshold, lvl1, lvl2;
  int mismatches, checks;
  ocm_monitor #(.SAMPLE_CYCLES(20)) u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .comp_power_en(comp_power_en), .comp_sel_two(comp_sel_two),
    .dac_threshold(dac_threshold), .cmp_result(cmp_result), .overcurrent_alert_irq(irq));
  ocm_comparator_model u_cmp (.clk(clk), .comp_power_en(comp_power_en),
    .comp_sel_two(comp_sel_two), .dac_threshold(dac_threshold), .sense_one_level(lvl1),
    .sense_two_level(lvl2), .cmp_result(cmp_result));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc(1);
    reg_addr = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    chk({2'h0, reg_rd_data}, {2'h0, e}, "rd_data");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    finish_test;
  end
  initial begin
    reset = 1'b1;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
    lvl1 = 10'h200;
    lvl2 = 10'h200;
    cyc(4);
    reset = 1'b0;
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    rd(8'h82, 8'h00);
    rd(8'h88, 8'h0F);
    rd(8'h90, 8'h00);
    wr(8'h80, 8'h7C);
    rd(8'h80, 8'h00);
    cyc(50);
    $display("test reset done");
    // Input one above its threshold, input two above its own
    wr(8'h88, 8'h02);
    wr(8'h84, 8'h10);
    wr(8'h85, 8'h00);
    wr(8'h86, 8'h00);
    wr(8'h87, 8'h01);
    wr(8'h80, 8'h01);
    cyc(30);
    rd(8'h81, 8'h00);
    cyc(100);
    rd(8'h80, 8'h81);
    rd(8'h81, 8'h01);
    rd(8'h82, 8'h41);
    chk(dac_threshold, 10'h010, "dac");
    wr(8'h82, 8'h00);
    rd(8'h82, 8'h41);
    wr(8'h82, 8'h41);
    rd(8'h82, 8'h00);
    wr(8'h83, 8'h01);
    chk({9'h0, irq}, 10'h000, "irq");
    lvl1 = 10'h000;
    cyc(120);
    chk({9'h0, irq}, 10'h001, "irq");
    rd(8'h81, 8'h00);
    wr(8'h82, 8'h01);
    cyc(2);
    chk({9'h0, irq}, 10'h000, "irq");
    $display("test single done");
    lvl1 = 10'h200;
    cyc(120);
    wr(8'h80, 8'h00);
    cyc(3);
    rd(8'h81, 8'h00);
    rd(8'h82, 8'h01);
    wr(8'h82, 8'h01);
    lvl1 = 10'h000;
    wr(8'h80, 8'h03);
    // Mode change lands clear of an alternation step
    cyc(210);
    rd(8'h81, 8'h02);
    rd(8'h82, 8'h82);
    wr(8'h80, 8'h02);
    cyc(60);
    chk({9'h0, comp_sel_two}, 10'h001, "sel_two");
    chk(dac_threshold, 10'h100, "dac");
    $display("test both done");
    finish_test;
  end
endmodule
`default_nettype wire

// file: tb/ocm_monitor_chk.sv
// Port checker for the overcurrent sense monitor
`timescale 1ns/1ps
`default_nettype none
module ocm_monitor_chk
  import ocm_pkg::*;
#(
  parameter int SAMPLE_CYCLES = OCM_SAMPLE_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  // Comparator and interrupt
  input wire logic comp_power_en,
  input wire logic comp_sel_two,
  input wire logic [9:0] dac_threshold,
  input wire logic cmp_result,
  input wire logic overcurrent_alert_irq
);
  logic [1:0] mode_q;
  logic [15:0] since_wr;
  logic ctl_wr;
  logic settled;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  assign ctl_wr = reg_wr_en && reg_addr == OCM_ADDR_CTL;
  // Two ticks after a control write the scheduler is past its settle tick
  assign settled = since_wr > 16'(2 * SAMPLE_CYCLES);
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= OCM_MODE_OFF;
      since_wr <= 16'h0000;
    end else if (ctl_wr) begin
      mode_q <= reg_wr_data[1:0];
      since_wr <= 16'h0000;
    end else if (since_wr != 16'hFFFF) begin
      since_wr <= since_wr + 16'h0001;
    end
  end
  property p_reset_quiet;
    disable iff (1'b0) reset |=> !comp_power_en && !overcurrent_alert_irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
  property p_power;
    ctl_wr |=> ##1 comp_power_en == ($past(mode_q) != OCM_MODE_OFF);
  endproperty
  a_power: assert property (p_power) else $error("comparator power wrong");
  property p_sel_single;
    (mode_q == OCM_MODE_ONE || mode_q == OCM_MODE_TWO) && settled |-> comp_sel_two == mode_q[1];
  endproperty
  a_sel_single: assert property (p_sel_single) else $error("wrong input sampled");
  property p_both_gap;
    mode_q == OCM_MODE_BOTH && settled && $changed(comp_sel_two) |=> $stable(comp_sel_two)[*8];
  endproperty
  a_both_gap: assert property (p_both_gap) else $error("input switched too soon");
  property p_both_turn;
    mode_q == OCM_MODE_BOTH && settled |-> ##[1:21] $changed(comp_sel_two);
  endproperty
  a_both_turn: assert property (p_both_turn) else $error("inputs not alternating");
  property p_ctl_rsvd;
    reg_rd_en && reg_addr == OCM_ADDR_CTL |=> reg_rd_data[6:2] == 5'h00;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits set");
  property p_match_rsvd;
    reg_rd_en && reg_addr == OCM_ADDR_MATCH |=> reg_rd_data[7:2] == 6'h00;
  endproperty
  a_match_rsvd: assert property (p_match_rsvd) else $error("match reserved bits set");
  property p_match_off;
    reg_rd_en && reg_addr == OCM_ADDR_MATCH && !ctl_wr && since_wr > 16'h0002
      |=> (reg_rd_data[1:0] & ~mode_q) == 2'h0;
  endproperty
  a_match_off: assert property (p_match_off) else $error("match set on idle input");
  property p_unmapped;
    reg_rd_en && reg_addr > OCM_ADDR_DEBOUNCE |=> reg_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_thr_low;
    reg_wr_en && (reg_addr == OCM_ADDR_THR1_LO || reg_addr == OCM_ADDR_THR2_LO)
      && mode_q != OCM_MODE_BOTH && settled |=> ##1 $stable(dac_threshold);
  endproperty
  a_thr_low: assert property (p_thr_low) else $error("threshold moved on low byte");
endmodule
bind ocm_monitor ocm_monitor_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.*);
`default_nettype wire
